// >>> include/pan_pkg.sv
// Package with register map, field layout and reset values of the advert/identifier bank
package pan_pkg;

   // Register indices on the management register port
   localparam logic [4:0] PAN_REG_ID_LOW = 5'h03;
   localparam logic [4:0] PAN_REG_ADVERT = 5'h04;

   // Identifier word field positions
   localparam int PAN_ID_OUI_LSB = 10;
   localparam int PAN_ID_MODEL_LSB = 4;
   localparam int PAN_ID_REV_LSB = 0;

   // Advertisement word bit positions
   localparam int PAN_ADV_NEXT_PAGE = 15;
   localparam int PAN_ADV_ACK = 14;
   localparam int PAN_ADV_REMOTE_FAULT = 13;
   localparam int PAN_ADV_RESERVED = 12;
   localparam int PAN_ADV_ASYM_PAUSE = 11;
   localparam int PAN_ADV_PAUSE = 10;
   localparam int PAN_ADV_T4 = 9;
   localparam int PAN_ADV_SPEED_LSB = 5;

   // Writable bits: 13, 12, 11, 10, 8, 7, 6, 5
   localparam logic [15:0] PAN_ADV_RW_MASK = 16'h3de0;
   // Selector field, fixed at IEEE 802.3
   localparam logic [15:0] PAN_ADV_SELECTOR = 16'h0001;
   // Reset value: four speed/duplex bits set, pause bits loaded later from straps
   localparam logic [15:0] PAN_ADV_RESET = 16'h01e1;

   // Cycles after reset release before straps are sampled through the synchroniser
   localparam logic [1:0] PAN_STRAP_LOAD_CYC = 2'h3;

   // One register request from the management frame engine
   typedef struct packed {
      logic req;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pan_mgmt_req_s;

   // Strap pins as one bundle
   typedef struct packed {
      logic fiber_100m_mode;
      logic fiber_asym_flowctl_strap;
      logic fiber_flowctl_strap;
      logic copper_asym_flowctl_strap;
      logic copper_flowctl_strap;
   } pan_strap_s;

endpackage : pan_pkg

// >>> logic/pan_advert_regs.sv
// Identifier and auto-negotiation advertisement registers of one PHY port
`timescale 1ns/1ps
`default_nettype none

module pan_advert_regs
#(
   parameter logic [5:0] OUI_BITS = 6'h15,  // Arbitrary value
   parameter logic [5:0] MODEL_NUM = 6'h0a, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h3    // Arbitrary value
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Register port from the frame engine
   input wire pan_pkg::pan_mgmt_req_s mgmt_in,
   output logic mgmt_ack_out,
   output logic mgmt_hit_out,
   output logic [15:0] mgmt_rdata_out,
   // Strap pins
   input wire pan_pkg::pan_strap_s strap_in,
   // To auto-negotiation transmit logic
   output logic [15:0] advert_word_out
);
   import pan_pkg::*;

   localparam logic [15:0] ID_WORD = {OUI_BITS, MODEL_NUM, REVISION};

   // Elaboration checks: the identifier fills one word, and the reset value
   // agrees with the read-only bits, and a retuned mask cannot leak into the selector field
   if ($bits(OUI_BITS) + $bits(MODEL_NUM) + $bits(REVISION) != 16)
   begin : g_bad_id
      $error("Identifier fields must total 16 bits");
   end
   if ((PAN_ADV_RESET & ~PAN_ADV_RW_MASK) != PAN_ADV_SELECTOR)
   begin : g_bad_reset
      $error("Advert reset value disagrees with the read-only bits");
   end
   if ((PAN_ADV_RW_MASK & 16'h001f) != 16'h0000)
   begin : g_bad_mask
      $error("Selector field must not be writable");
   end

   // Synchroniser flops for the strap pins
   logic [4:0] strap_m_q;
   logic [4:0] strap_s_q;
   pan_strap_s strap_sync;
   // Countdown that picks the one cycle in which the straps are loaded
   logic [1:0] strap_cnt_q;
   logic [1:0] strap_cnt_d;
   // Stored advertisement word and the response flops
   logic [15:0] adv_q;
   logic [15:0] adv_d;
   logic ack_q;
   logic hit_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // One strap of a pair, chosen by the port mode; used for both pause bits
   function automatic logic pick_strap(input logic fiber_mode, input logic fiber_val,
                                       input logic copper_val);
      return fiber_mode ? fiber_val : copper_val;
   endfunction : pick_strap

   // Request decode
   wire req_id = mgmt_in.req && (mgmt_in.addr == PAN_REG_ID_LOW);
   wire req_adv = mgmt_in.req && (mgmt_in.addr == PAN_REG_ADVERT);
   wire wr_adv = req_adv && mgmt_in.wr;
   // Write value: read-only bits are forced, so a write can never disturb them
   wire [15:0] adv_wr_val = (mgmt_in.wdata & PAN_ADV_RW_MASK)
                            | PAN_ADV_SELECTOR;

   // Straps are pins: two flops before anything looks at them
   assign strap_sync = pan_strap_s'(strap_s_q);
   wire strap_load = (strap_cnt_q == 2'h1);
   wire pause_sel = pick_strap(strap_sync.fiber_100m_mode, strap_sync.fiber_flowctl_strap,
                               strap_sync.copper_flowctl_strap);
   wire asym_sel = pick_strap(strap_sync.fiber_100m_mode, strap_sync.fiber_asym_flowctl_strap,
                              strap_sync.copper_asym_flowctl_strap);

   // Next advert value; a write in the load cycle wins over the straps
   always_comb
   begin
      adv_d = adv_q;
      strap_cnt_d = (strap_cnt_q != 2'h0) ? strap_cnt_q - 2'h1 : 2'h0;
      if (wr_adv)
      begin
         adv_d = adv_wr_val;
      end
      else if (strap_load)
      begin
         adv_d[PAN_ADV_PAUSE] = pause_sel;
         adv_d[PAN_ADV_ASYM_PAUSE] = asym_sel;
      end
   end

   // Read mux; other addresses answer zero and do not claim the access
   assign rdata_d = req_id ? ID_WORD :
                    req_adv ? adv_q : 16'h0000;

   // Synchroniser stages
   always_ff @(posedge sys_clk_in)
   begin
      strap_m_q <= strap_in;
      strap_s_q <= strap_m_q;
   end

   // Advert word and strap countdown; reset restores defaults and rearms the load
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         adv_q <= PAN_ADV_RESET;
         strap_cnt_q <= PAN_STRAP_LOAD_CYC;
      end
      else
      begin
         adv_q <= adv_d;
         strap_cnt_q <= strap_cnt_d;
      end
   end

   // Response flops; read data drops to zero between answers, so a stale word
   // can never be mistaken for a fresh one
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         ack_q <= 1'b0;
         hit_q <= 1'b0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         ack_q <= mgmt_in.req;
         hit_q <= req_id || req_adv;
         rdata_q <= mgmt_in.wr ? 16'h0000 : rdata_d;
      end
   end

   // Pause bits leave in the advert word and in read data of the advert register
   assign advert_word_out = adv_q;
   assign mgmt_ack_out = ack_q;
   assign mgmt_hit_out = hit_q;
   assign mgmt_rdata_out = rdata_q;

   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   // Identifier word and the fixed bits of the advert word
   id_read_value_a: assert property (req_id && !mgmt_in.wr |=>
                                     mgmt_rdata_out == ID_WORD)
      else $error("Identifier read returned wrong word");
   next_page_zero_a: assert property (advert_word_out[PAN_ADV_NEXT_PAGE] == 1'b0)
      else $error("Next page bit not zero");
   ack_bit_zero_a: assert property (advert_word_out[PAN_ADV_ACK] == 1'b0)
      else $error("Acknowledge bit not zero");
   t4_bit_zero_a: assert property (advert_word_out[PAN_ADV_T4] == 1'b0)
      else $error("T4 bit not zero");
   selector_fixed_a: assert property (advert_word_out[4:0] == 5'h01)
      else $error("Selector field changed");

   // Writable bits follow writes, and otherwise change only in the strap load
   write_takes_a: assert property (wr_adv |=> (advert_word_out & PAN_ADV_RW_MASK)
                                   == ($past(mgmt_in.wdata) & PAN_ADV_RW_MASK))
      else $error("Advert write not stored");
   no_write_hold_a: assert property (!wr_adv && !strap_load |=>
                                     $stable(advert_word_out))
      else $error("Advert changed without a write");
   adv_readback_a: assert property (req_adv && !mgmt_in.wr |=>
                                    mgmt_rdata_out == $past(advert_word_out))
      else $error("Advert read does not match stored value");

   // Strap load takes the pair of the port mode, written out apart from the mux
   strap_pause_a: assert property (strap_load && !wr_adv |=>
      advert_word_out[PAN_ADV_PAUSE] == ($past(strap_sync.fiber_100m_mode)
      ? $past(strap_sync.fiber_flowctl_strap) : $past(strap_sync.copper_flowctl_strap)))
      else $error("Pause bit not loaded from strap");
   strap_asym_a: assert property (strap_load && !wr_adv |=>
      advert_word_out[PAN_ADV_ASYM_PAUSE] == ($past(strap_sync.fiber_100m_mode)
      ? $past(strap_sync.fiber_asym_flowctl_strap)
      : $past(strap_sync.copper_asym_flowctl_strap)))
      else $error("Asymmetric pause bit not loaded from strap");
   reset_default_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
                                     rst_in |=> advert_word_out[8:5] == 4'hf
                                     && advert_word_out[13:12] == 2'h0)
      else $error("Advert reset value wrong");

   // Every request is answered exactly one cycle later, and only then
   ack_follows_req_a: assert property (mgmt_in.req |=> mgmt_ack_out)
      else $error("Request not acknowledged");
   ack_only_req_a: assert property (!mgmt_in.req |=> !mgmt_ack_out)
      else $error("Acknowledge without a request");
   unmapped_miss_a: assert property (mgmt_in.req && !req_id && !req_adv |=>
                                     !mgmt_hit_out && mgmt_rdata_out == 16'h0000)
      else $error("Unmapped address claimed");
   write_rdata_zero_a: assert property (mgmt_in.req && mgmt_in.wr |=>
                                        mgmt_rdata_out == 16'h0000)
      else $error("Write returned read data");

   // Main scenarios
   write_clear_speed_c: cover property (wr_adv && mgmt_in.wdata[8:5] == 4'h0);
   strap_load_c: cover property (strap_load && !wr_adv && pause_sel);
   write_then_read_c: cover property (wr_adv ##1 req_adv && !mgmt_in.wr);
   fiber_load_c: cover property (strap_load && strap_sync.fiber_100m_mode);

endmodule : pan_advert_regs

`default_nettype wire

// >>> test/pan_mgmt_master.sv
// Management master model that issues register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module pan_mgmt_master
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Request toward the register bank
   output var pan_pkg::pan_mgmt_req_s mgmt_out
);
   import pan_pkg::*;
   int idle_cnt = 0;
   // Cycles since reset; the first frame needs a full preamble first
   always @(posedge sys_clk_in)
      idle_cnt <= rst_in ? 0 : idle_cnt + 1;
   initial mgmt_out = '0;
   // One request per call, launched at the falling edge, back to back allowed
   task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata);
      while (idle_cnt < 32) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      mgmt_out <= '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
   endtask : access
   // Released request lines do not keep the last data
   task automatic idle();
      @(negedge sys_clk_in);
      mgmt_out <= '{req: 1'b0, wr: ~mgmt_out.wr, addr: ~mgmt_out.addr, wdata: ~mgmt_out.wdata};
   endtask : idle
endmodule : pan_mgmt_master
`default_nettype wire

// >>> test/pan_advert_regs_bench.sv
// Self-checking bench for the identifier and advertisement registers
`timescale 1ns/1ps
`default_nettype none
module pan_advert_regs_bench;
   import pan_pkg::*;
   localparam logic [15:0] ID = 16'h54a3; // Default identifier parameters
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   pan_mgmt_req_s mgmt;
   pan_strap_s strap = '0;
   logic ack, hit;
   logic [15:0] rdata, advert, mirror;
   logic [16:0] exp_q[$];
   int errors = 0;
   int checks = 0;
   int seed = 74;
   pan_mgmt_master u_pan_mgmt_master (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .mgmt_out(mgmt));
   pan_advert_regs u_pan_advert_regs (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .mgmt_in(mgmt),
      .mgmt_ack_out(ack), .mgmt_hit_out(hit), .mgmt_rdata_out(rdata), .strap_in(strap),
      .advert_word_out(advert));
   // Clock, 8 ns period
   initial forever #4 sys_clk_in = ~sys_clk_in;
   task automatic report(input string what, input logic [16:0] exp, input logic [16:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : report
   task automatic check_resp(input logic [16:0] exp);
      report("response", exp, {hit, rdata});
   endtask : check_resp
   task automatic check_adv(input logic [15:0] exp);
      report("advert word", {1'b0, exp}, {1'b0, advert});
   endtask : check_adv
   // Every noted response must have been answered by an acknowledge
   task automatic check_drain();
      report("responses left", 17'h0, 17'(exp_q.size()));
   endtask : check_drain
   // Each acknowledge retires the oldest noted response
   always @(negedge sys_clk_in)
      if (ack === 1'b1)
         check_resp(exp_q.size() ? exp_q.pop_front() : 17'h1ffff);
   // Note the expected answer, then hand the request to the master model
   task automatic acc(input logic wr, input logic [4:0] addr, input logic [15:0] wd);
      logic [15:0] rd;
      if (wr && addr == PAN_REG_ADVERT)
         mirror = (wd & PAN_ADV_RW_MASK) | PAN_ADV_SELECTOR;
      rd = wr ? 16'h0 : addr == PAN_REG_ID_LOW ? ID : addr == PAN_REG_ADVERT ? mirror : 16'h0;
      exp_q.push_back({addr == PAN_REG_ID_LOW || addr == PAN_REG_ADVERT, rd});
      u_pan_mgmt_master.access(wr, addr, wd);
   endtask : acc
   // Straps settle before release; pause bits follow the mode-selected pair
   task automatic do_reset(input logic [4:0] s);
      u_pan_mgmt_master.idle();
      strap <= s;
      rst_in <= 1'b1;
      repeat (12) @(negedge sys_clk_in);
      check_adv(PAN_ADV_RESET);
      rst_in <= 1'b0;
      repeat (4) @(negedge sys_clk_in);
      mirror = PAN_ADV_RESET | (16'(s[4] ? s[3:2] : s[1:0]) << PAN_ADV_PAUSE);
      check_adv(mirror);
   endtask : do_reset
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // Copper mode first, then fiber mode with a reset over written values
   initial
   begin
      for (int m = 0; m < 2; m++)
      begin
         do_reset({m[0], 4'($random(seed))});
         acc(1'b0, PAN_REG_ADVERT, 16'h0);
         acc(1'b0, PAN_REG_ID_LOW, 16'h0);
         acc(1'b1, PAN_REG_ID_LOW, 16'hffff);
         acc(1'b0, PAN_REG_ID_LOW, 16'h0);
         acc(1'b1, PAN_REG_ADVERT, 16'hffff);
         acc(1'b0, PAN_REG_ADVERT, 16'h0);
         acc(1'b1, 5'h05, 16'h0);
         acc(1'b0, 5'h05, 16'h0);
         acc(1'b1, PAN_REG_ADVERT, 16'h0);
         acc(1'b0, PAN_REG_ADVERT, 16'h0);
         for (int i = 0; i < 20; i++)
            acc(1'($random(seed)), PAN_REG_ADVERT, 16'($random(seed)));
         u_pan_mgmt_master.idle();
         @(negedge sys_clk_in);
         check_adv(mirror);
         check_drain();
      end
      stop_test();
   end
   // Watchdog far beyond the roughly 155 cycles the run needs
   initial
   begin
      #20000;
      errors++;
      stop_test();
   end
endmodule : pan_advert_regs_bench
`default_nettype wire
